// [cmpr_cfg.svh]
// Register offsets, field positions, reset values and counts
`ifndef CMPR_CFG_SVH
`define CMPR_CFG_SVH
`define CMPR_NUM 2
`define CMPR_OFF_CFG1 12'h000
`define CMPR_OFF_SEL1 12'h004
`define CMPR_OFF_CFG2 12'h008
`define CMPR_OFF_SEL2 12'h00C
`define CMPR_OFF_MIRROR 12'h010
`define CMPR_OFF_IRQ_STAT 12'h014
`define CMPR_OFF_IRQ_MASK 12'h018
`define CMPR_OFF_PORT 12'h01C
`define CMPR_CFG_WMASK 8'hB7
`define CMPR_SEL_WMASK 8'hF3
`define CMPR_CFG_RESET 8'h04
`define CMPR_SEL_RESET 8'h00
`define CMPR_B_ENABLE 7
`define CMPR_B_RESULT 6
`define CMPR_B_PIN_DRIVE 5
`define CMPR_B_INVERT 4
`define CMPR_B_SPEED 2
`define CMPR_B_HYST 1
`define CMPR_B_SYNC 0
`define CMPR_B_RISE_IE 7
`define CMPR_B_FALL_IE 6
`define CMPR_F_POS_HI 5
`define CMPR_F_POS_LO 4
`define CMPR_F_NEG_HI 1
`define CMPR_F_NEG_LO 0
`define CMPR_PORT_W 6
`endif

// [cmpr_pkg.sv]
// Types shared by the comparator register block
package cmpr_pkg;
  typedef logic [7:0] cmpr_byte_t;
  typedef logic [1:0] cmpr_chan_t;
  typedef enum logic [1:0] {
    CMPR_POS_PIN,
    CMPR_POS_DAC,
    CMPR_POS_FIXED_REF,
    CMPR_POS_GROUND
  } cmpr_pos_sel_t;
endpackage

// [cmpr_regs.sv]
// Comparator control and status registers behind an AHB-Lite slave
//
// Chosen here: the AHB-Lite slave port and the address map.
`include "cmpr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module cmpr_regs (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Analog core side, raw comparisons from pins
  input wire logic [`CMPR_NUM-1:0] raw_compare,
  input wire logic [`CMPR_NUM-1:0] gate_timer_clk,
  // Port pins sharing comparator inputs
  input wire logic [`CMPR_PORT_W-1:0] port_pin_in,
  input wire logic [`CMPR_PORT_W-1:0] port_analog_sel,
  // Pin direction, low means pin may be driven
  input wire logic [`CMPR_NUM-1:0] pin_direction,
  // Analog core controls
  output logic [`CMPR_NUM-1:0] core_enable,
  output logic [`CMPR_NUM-1:0] core_speed,
  output logic [`CMPR_NUM-1:0] core_hysteresis,
  output cmpr_pkg::cmpr_chan_t core_pos_sel [`CMPR_NUM],
  output cmpr_pkg::cmpr_chan_t core_neg_sel [`CMPR_NUM],
  // Result outputs
  output logic [`CMPR_NUM-1:0] gate_timer_result,
  output logic [`CMPR_NUM-1:0] pin_out,
  output logic [`CMPR_NUM-1:0] pin_oe,
  // Interrupt
  output logic cmp_irq
);
  import cmpr_pkg::*;

  // Bus address phase capture
  logic wr_pend_q;
  logic [11:0] addr_q;
  wire logic take = hsel & hready & htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      addr_q <= 12'h000;
    end else begin
      wr_pend_q <= take & hwrite;
      addr_q <= take ? haddr : addr_q;
    end
  end

  // Write strobes in data phase
  wire logic wr_cfg1 = wr_pend_q & (addr_q == `CMPR_OFF_CFG1);
  wire logic wr_sel1 = wr_pend_q & (addr_q == `CMPR_OFF_SEL1);
  wire logic wr_cfg2 = wr_pend_q & (addr_q == `CMPR_OFF_CFG2);
  wire logic wr_sel2 = wr_pend_q & (addr_q == `CMPR_OFF_SEL2);
  wire logic wr_stat = wr_pend_q & (addr_q == `CMPR_OFF_IRQ_STAT);
  wire logic wr_mask = wr_pend_q & (addr_q == `CMPR_OFF_IRQ_MASK);
  wire logic [`CMPR_NUM-1:0] wr_cfg = {wr_cfg2, wr_cfg1};
  wire logic [`CMPR_NUM-1:0] wr_sel = {wr_sel2, wr_sel1};

  // Port inputs are asynchronous pins, two stages first
  logic [`CMPR_PORT_W-1:0] port_s1_q;
  logic [`CMPR_PORT_W-1:0] port_s2_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_s1_q <= '0;
      port_s2_q <= '0;
    end else begin
      port_s1_q <= port_pin_in;
      port_s2_q <= port_s1_q;
    end
  end
  // Analog pins read zero
  wire logic [`CMPR_PORT_W-1:0] port_view = port_s2_q & ~port_analog_sel;

  cmpr_byte_t cfg_q [`CMPR_NUM];
  cmpr_byte_t sel_q [`CMPR_NUM];
  logic [`CMPR_NUM-1:0] result_q;
  logic [`CMPR_NUM-1:0] flag_q;
  logic [`CMPR_NUM-1:0] mask_q;

  genvar g;
  generate
    for (g = 0; g < `CMPR_NUM; g = g + 1) begin : gen_cmp
      logic raw_s1_q;
      logic raw_s2_q;
      logic prev_q;
      logic tclk_s1_q;
      logic tclk_s2_q;
      logic tclk_s3_q;
      logic sync_res_q;
      wire logic en = cfg_q[g][`CMPR_B_ENABLE];
      wire logic inv = cfg_q[g][`CMPR_B_INVERT];
      // Disabled core reads low before polarity
      wire logic gated = raw_s2_q & en;
      wire logic polar = gated ^ inv;
      // Rising or falling change of the latched result
      wire logic rise = result_q[g] & ~prev_q;
      wire logic fall = ~result_q[g] & prev_q;
      wire logic ev = (rise & sel_q[g][`CMPR_B_RISE_IE])
                    | (fall & sel_q[g][`CMPR_B_FALL_IE]);
      wire logic tclk_fall = tclk_s3_q & ~tclk_s2_q;
      // Path to timer and pin, resampled on timer clock fall if asked
      wire logic path = cfg_q[g][`CMPR_B_SYNC] ? sync_res_q
                                               : result_q[g];
      wire logic [31:0] wd = hwdata;

      // Raw comparison is asynchronous, two stages before use
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          raw_s1_q <= 1'b0;
          raw_s2_q <= 1'b0;
          tclk_s1_q <= 1'b0;
          tclk_s2_q <= 1'b0;
          tclk_s3_q <= 1'b0;
        end else begin
          raw_s1_q <= raw_compare[g];
          raw_s2_q <= raw_s1_q;
          tclk_s1_q <= gate_timer_clk[g];
          tclk_s2_q <= tclk_s1_q;
          tclk_s3_q <= tclk_s2_q;
        end
      end

      // Latch once per cycle; toggling enable or invert shows up here
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          result_q[g] <= 1'b0;
          prev_q <= 1'b0;
        end else begin
          result_q[g] <= polar;
          prev_q <= result_q[g];
        end
      end

      // Timer resample of the result
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync_res_q <= 1'b0;
        end else if (tclk_fall) begin
          sync_res_q <= result_q[g];
        end
      end

      // Control registers, writable bits masked
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cfg_q[g] <= `CMPR_CFG_RESET;
          sel_q[g] <= `CMPR_SEL_RESET;
        end else begin
          if (wr_cfg[g]) begin
            cfg_q[g] <= wd[7:0] & `CMPR_CFG_WMASK;
          end
          if (wr_sel[g]) begin
            sel_q[g] <= wd[7:0] & `CMPR_SEL_WMASK;
          end
        end
      end

      // Sticky flag: a new edge wins over the clearing write
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          flag_q[g] <= 1'b0;
        end else begin
          flag_q[g] <= ev | (flag_q[g] & ~(wr_stat & wd[g]));
        end
      end

      // Core controls and pin outputs, all registered
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          core_enable[g] <= 1'b0;
          core_speed[g] <= 1'b1;
          core_hysteresis[g] <= 1'b0;
          core_pos_sel[g] <= 2'h0;
          core_neg_sel[g] <= 2'h0;
          gate_timer_result[g] <= 1'b0;
          pin_out[g] <= 1'b0;
          pin_oe[g] <= 1'b0;
        end else begin
          core_enable[g] <= en;
          core_speed[g] <= cfg_q[g][`CMPR_B_SPEED];
          core_hysteresis[g] <= cfg_q[g][`CMPR_B_HYST];
          core_pos_sel[g] <=
            sel_q[g][`CMPR_F_POS_HI:`CMPR_F_POS_LO];
          core_neg_sel[g] <=
            sel_q[g][`CMPR_F_NEG_HI:`CMPR_F_NEG_LO];
          gate_timer_result[g] <= path;
          pin_out[g] <= path;
          // Enable bit has no say on the pin override
          pin_oe[g] <= cfg_q[g][`CMPR_B_PIN_DRIVE]
                       & ~pin_direction[g];
        end
      end
    end
  endgenerate

  // Interrupt mask register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_q <= '0;
    end else if (wr_mask) begin
      mask_q <= hwdata[`CMPR_NUM-1:0];
    end
  end

  // Config read view carries the live result in bit 6
  wire logic [7:0] cfg1_rd = cfg_q[0] | ({7'h00, result_q[0]} << `CMPR_B_RESULT);
  wire logic [7:0] cfg2_rd = cfg_q[1] | ({7'h00, result_q[1]} << `CMPR_B_RESULT);
  wire logic [7:0] mirror = {6'h00, result_q};

  // Read mux on the address phase, so data is ready next cycle
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h0000_0000;
    case (haddr)
      `CMPR_OFF_CFG1: rd_d = {24'h000000, cfg1_rd};
      `CMPR_OFF_SEL1: rd_d = {24'h000000, sel_q[0]};
      `CMPR_OFF_CFG2: rd_d = {24'h000000, cfg2_rd};
      `CMPR_OFF_SEL2: rd_d = {24'h000000, sel_q[1]};
      `CMPR_OFF_MIRROR: rd_d = {24'h000000, mirror};
      `CMPR_OFF_IRQ_STAT: rd_d = {30'h00000000, flag_q};
      `CMPR_OFF_IRQ_MASK: rd_d = {30'h00000000, mask_q};
      `CMPR_OFF_PORT: rd_d = {26'h0000000, port_view};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Read data register, interrupt output registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      cmp_irq <= 1'b0;
    end else begin
      hrdata <= (take & ~hwrite) ? rd_d : hrdata;
      cmp_irq <= |(flag_q & mask_q);
    end
  end

  // Zero wait states and always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [cmpr_regs_props.sv]
// Port-level checks for the comparator register block
`timescale 1ns/1ps
`default_nettype none
`include "cmpr_cfg.svh"
module cmpr_regs_props (
  // Clock, reset and bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Core side
  input wire logic [`CMPR_NUM-1:0] raw_compare,
  input wire logic [`CMPR_NUM-1:0] pin_direction,
  input wire logic [`CMPR_NUM-1:0] core_enable,
  input wire logic [`CMPR_NUM-1:0] core_speed,
  input wire logic [`CMPR_NUM-1:0] core_hysteresis,
  input wire logic [`CMPR_NUM-1:0] pin_oe,
  input wire logic cmp_irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Taken requests
  wire wr = hsel & hready & htrans[1] & hwrite;
  wire rd = hsel & hready & htrans[1] & ~hwrite;
  // Cycles since the last thing that may cause a result edge
  logic [3:0] quiet_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) quiet_q <= 4'h0;
    else if (wr || $changed(raw_compare)) quiet_q <= 4'h0;
    else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
  end
  AST_RST_VAL: assert property ($rose(hresetn) |->
    core_speed == '1 && core_enable == '0 && !cmp_irq)
    else $error("reset values wrong");
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");
  AST_RD_HOLD: assert property ($changed(hrdata) |-> $past(rd))
    else $error("read data moved without a read");
  AST_ENA_WR: assert property ($changed(core_enable) |->
    $past(wr, 2) || $past(wr, 3) || $past(wr, 4))
    else $error("enable changed without a write");
  AST_MODE_WR: assert property (
    $changed({core_speed, core_hysteresis}) |->
    $past(wr, 2) || $past(wr, 3) || $past(wr, 4))
    else $error("speed or hysteresis changed without a write");
  AST_OE_DIR: assert property ($stable(pin_direction) |->
    (pin_oe & pin_direction) == '0)
    else $error("pin driven while set as input");
  AST_IRQ_CAUSE: assert property ($rose(cmp_irq) |->
    quiet_q < 4'hC)
    else $error("interrupt rose without a cause");
  AST_IRQ_CLR: assert property ($fell(cmp_irq) |->
    $past(wr, 2) || $past(wr, 3) || $past(wr, 4))
    else $error("interrupt fell without a write");
  // Main scenarios
  cover property ($rose(cmp_irq));
  cover property ($fell(cmp_irq));
  cover property (pin_oe != '0);
endmodule
bind cmpr_regs cmpr_regs_props u_props (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .raw_compare(raw_compare), .pin_direction(pin_direction),
  .core_enable(core_enable), .core_speed(core_speed),
  .core_hysteresis(core_hysteresis), .pin_oe(pin_oe), .cmp_irq(cmp_irq));
`default_nettype wire

// [cmpr_regs_bench.sv]
// Self-checking bench for the comparator register block
`timescale 1ns/1ps
`default_nettype none
`include "cmpr_cfg.svh"
module cmpr_regs_bench;
  import cmpr_pkg::*;
  typedef struct packed {
    logic w; logic [11:0] a; logic [7:0] d; logic [1:0] raw; logic [7:0] e;
  } cmpr_row_t;
  // Bench drive
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0, raw_compare = 2'h0;
  logic [1:0] gate_timer_clk = 2'h3, pin_direction = 2'h3;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, q;
  logic [5:0] port_pin_in = 6'h3F, port_analog_sel = 6'h0F;
  // Design outputs
  wire [31:0] hrdata;
  wire hreadyout, hresp, cmp_irq;
  wire [1:0] core_enable, core_speed, core_hysteresis;
  wire [1:0] gate_timer_result, pin_out, pin_oe;
  cmpr_chan_t core_pos_sel [2];
  cmpr_chan_t core_neg_sel [2];
  int num_errors = 0, n_checks = 0, cyc = 0;
  // Reads go after writes settle; results lag the pins by a few edges
  cmpr_row_t rows [13] = '{
    '{0, `CMPR_OFF_CFG1, 8'h00, 2'h0, 8'h04},
    '{0, `CMPR_OFF_SEL1, 8'h00, 2'h0, 8'h00},
    '{0, `CMPR_OFF_MIRROR, 8'h00, 2'h0, 8'h00},
    '{1, `CMPR_OFF_CFG1, 8'hFF, 2'h0, 8'h00},
    '{0, `CMPR_OFF_CFG1, 8'h00, 2'h0, 8'hF7},
    '{1, `CMPR_OFF_SEL1, 8'hFF, 2'h0, 8'h00},
    '{0, `CMPR_OFF_SEL1, 8'h00, 2'h0, 8'hF3},
    '{1, `CMPR_OFF_CFG2, 8'h80, 2'h2, 8'h00},
    '{0, `CMPR_OFF_MIRROR, 8'h00, 2'h2, 8'h03},
    '{0, `CMPR_OFF_CFG2, 8'h00, 2'h2, 8'hC0},
    '{1, 12'h100, 8'hFF, 2'h2, 8'h00},
    '{0, 12'h100, 8'h00, 2'h2, 8'h00},
    '{0, `CMPR_OFF_PORT, 8'h00, 2'h2, 8'h30}};
  cmpr_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .raw_compare(raw_compare),
    .gate_timer_clk(gate_timer_clk), .port_pin_in(port_pin_in),
    .port_analog_sel(port_analog_sel), .pin_direction(pin_direction),
    .core_enable(core_enable), .core_speed(core_speed),
    .core_hysteresis(core_hysteresis), .core_pos_sel(core_pos_sel),
    .core_neg_sel(core_neg_sel), .gate_timer_result(gate_timer_result),
    .pin_out(pin_out), .pin_oe(pin_oe), .cmp_irq(cmp_irq));
  always #12.5 hclk = ~hclk;
  // Hang guard, well above the run length
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One single AHB transfer, entered just after a rising edge
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
    repeat (8) @(posedge hclk);
  endtask
  task rdc(input logic [11:0] a, input logic [7:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, {24'h0, e});
  endtask
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (rows[i]) begin
      raw_compare <= rows[i].raw;
      repeat (8) @(posedge hclk);
      bus(rows[i].w, rows[i].a, {24'h0, rows[i].d});
      if (!rows[i].w) chk(q, {24'h0, rows[i].e});
    end
    repeat (8) @(posedge hclk);
    chk({core_enable, core_speed, core_hysteresis}, 6'h35);
    chk({core_pos_sel[0], core_neg_sel[0]}, 4'hF);
    for (int c = 0; c < 4; c++) begin
      wr(`CMPR_OFF_SEL2, {2'h0, c[1:0], 2'h0, c[1:0]});
      chk({core_pos_sel[1], core_neg_sel[1]}, {c[1:0], c[1:0]});
    end
    $display("table and channel tests done");
    // Edge flags, mask and clear
    wr(`CMPR_OFF_IRQ_STAT, 8'h03);
    wr(`CMPR_OFF_CFG1, 8'hA7);
    chk(cmp_irq, 1'b0);
    rdc(`CMPR_OFF_IRQ_STAT, 8'h01);
    wr(`CMPR_OFF_IRQ_MASK, 8'h03);
    chk(cmp_irq, 1'b1);
    wr(`CMPR_OFF_IRQ_STAT, 8'h01);
    chk(cmp_irq, 1'b0);
    wr(`CMPR_OFF_SEL1, 8'h40);
    wr(`CMPR_OFF_CFG1, 8'hB7);
    chk(cmp_irq, 1'b0);
    wr(`CMPR_OFF_CFG1, 8'h37);
    wr(`CMPR_OFF_CFG1, 8'h27);
    chk(cmp_irq, 1'b1);
    rdc(`CMPR_OFF_CFG1, 8'h27);
    wr(`CMPR_OFF_IRQ_STAT, 8'h03);
    $display("interrupt tests done");
    // Pin drive with the comparator off
    pin_direction <= 2'h2;
    repeat (8) @(posedge hclk);
    chk(pin_oe, 2'h1);
    chk(pin_out[0], 1'b0);
    // Timer-synchronised path holds until the timer clock falls
    wr(`CMPR_OFF_CFG2, 8'h81);
    // Resample register starts low; one timer fall loads the high result
    gate_timer_clk <= 2'h1;
    repeat (8) @(posedge hclk);
    gate_timer_clk <= 2'h3;
    repeat (8) @(posedge hclk);
    raw_compare <= 2'h0;
    repeat (12) @(posedge hclk);
    chk(gate_timer_result[1], 1'b1);
    gate_timer_clk <= 2'h1;
    repeat (8) @(posedge hclk);
    chk(gate_timer_result[1], 1'b0);
    $display("pin and sync tests done");
    // Reset in mid-run
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(core_speed, 2'h3);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(`CMPR_OFF_CFG1, 8'h04);
    $display("reset test done");
    complete_run();
  end
endmodule
`default_nettype wire
